//--- hw/dutcl_top.sv
/*
 * DAC update control: sequencer timers, clear control and load
 * requests for eight quad DACs, reached over AXI4-Lite.
 * Assumes the DAC transfer engine reports per-DAC data readiness and
 * that the serial engine consumes update and clear levels.
 */
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "dutcl_cfg.svh"

module dutcl_top import dutcl_pkg::*; #(
    parameter int NDAC = 8,
    parameter int PW = 32
) (
    input wire logic aclk, // Clock, 125 MHz
    input wire logic aresetn, // Sync reset, active low
    input wire logic [11:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [11:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [NDAC-1:0] dac_data_ready, // All channel data moved
    output logic [NDAC-1:0] dac_force_clear, // Per-DAC clear level
    output logic [NDAC-1:0] dac_update, // Output update pulse
    output logic [NDAC-1:0] seq_update // Timed update pulse
);
    localparam int TICK_CYC =
        (`DUTCL_CLK_HZ / 1000) * `DUTCL_TICK_NS / 1000000;
    localparam int OSC_CYC = `DUTCL_OSC_HZ / 100000;
    localparam int TW = $clog2(TICK_CYC);

    // ****************************************
    // Register storage
    // ****************************************
    logic [PW-1:0] preload_q [NDAC];
    logic [NDAC-1:0] clear_q;
    logic [NDAC-1:0] load_q;
    logic [NDAC*`DUTCL_MODE_W-1:0] mode_q;
    logic [NDAC-1:0] run_q;
    logic [NDAC-1:0] fire;
    logic [NDAC-1:0] upd_strobe;

    function automatic dutcl_mode_t mode_of(input int i,
            input logic [NDAC*`DUTCL_MODE_W-1:0] m);
        mode_of = dutcl_mode_t'(m[i*`DUTCL_MODE_W +: `DUTCL_MODE_W]);
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] old,
            input logic [31:0] d, input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            wmerge[b*8 +: 8] = s[b] ? d[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction

    // ****************************************
    // Write channel
    // ****************************************
    dutcl_wst_t wst_q;
    logic [11:0] waddr_q;
    logic waddr_ok_q;
    logic wdata_ok_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go;

    assign wr_go = (wst_q == DUTCL_ST_WDATA);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_q <= DUTCL_ST_IDLE;
            waddr_ok_q <= 1'b0;
            wdata_ok_q <= 1'b0;
            waddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            case (wst_q)
                DUTCL_ST_IDLE: begin
                    s_axi_awready <= !waddr_ok_q;
                    s_axi_wready <= !wdata_ok_q;
                    if (s_axi_awvalid && s_axi_awready) begin
                        waddr_q <= s_axi_awaddr;
                        waddr_ok_q <= 1'b1;
                        s_axi_awready <= 1'b0;
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        wdata_q <= s_axi_wdata;
                        wstrb_q <= s_axi_wstrb;
                        wdata_ok_q <= 1'b1;
                        s_axi_wready <= 1'b0;
                    end
                    if ((waddr_ok_q || (s_axi_awvalid && s_axi_awready)) &&
                        (wdata_ok_q || (s_axi_wvalid && s_axi_wready))) begin
                        wst_q <= DUTCL_ST_WDATA;
                        s_axi_awready <= 1'b0;
                        s_axi_wready <= 1'b0;
                    end
                end
                DUTCL_ST_WDATA: begin
                    s_axi_bvalid <= 1'b1;
                    s_axi_bresp <= wr_hit(waddr_q) ? 2'h0 : 2'h2;
                    wst_q <= DUTCL_ST_RESP;
                end
                DUTCL_ST_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        waddr_ok_q <= 1'b0;
                        wdata_ok_q <= 1'b0;
                        wst_q <= DUTCL_ST_IDLE;
                    end
                end
                default: wst_q <= DUTCL_ST_IDLE;
            endcase
        end
    end

    function automatic logic wr_hit(input logic [11:0] a);
        wr_hit = (a[11:5] == `DUTCL_OFS_PRELOAD0 >> 5) ||
            (a == `DUTCL_OFS_CLEAR) || (a == `DUTCL_OFS_LOAD) ||
            (a == `DUTCL_OFS_MODE) || (a == `DUTCL_OFS_RUN) ||
            (a == `DUTCL_OFS_READY);
    endfunction

    // ****************************************
    // Register writes
    // ****************************************
    // Mode word merged under the byte strobes
    logic [31:0] mode_wr;
    assign mode_wr = wmerge({8'h00, mode_q}, wdata_q, wstrb_q);

    genvar gi;
    generate
        for (gi = 0; gi < NDAC; gi++) begin : g_pre
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    preload_q[gi] <= `DUTCL_PRELOAD_RST;
                end else if (wr_go && waddr_q ==
                    `DUTCL_OFS_PRELOAD0 + 12'(gi * 4)) begin
                    preload_q[gi] <= wmerge(preload_q[gi], wdata_q, wstrb_q);
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clear_q <= `DUTCL_BITS_RST;
            mode_q <= `DUTCL_MODE_RST;
            run_q <= `DUTCL_BITS_RST;
        end else if (wr_go) begin
            if (waddr_q == `DUTCL_OFS_CLEAR && wstrb_q[0]) begin
                clear_q <= wdata_q[NDAC-1:0];
            end
            if (waddr_q == `DUTCL_OFS_MODE) begin
                mode_q <= mode_wr[23:0];
            end
            if (waddr_q == `DUTCL_OFS_RUN && wstrb_q[0]) begin
                run_q <= wdata_q[NDAC-1:0];
            end
        end
    end

    // ****************************************
    // Load requests and update decision
    // ****************************************
    logic [NDAC-1:0] gmem;
    logic [NDAC-1:0] gmem_pend;
    logic gmem_all_ready;

    generate
        for (gi = 0; gi < NDAC; gi++) begin : g_mode
            assign gmem[gi] = mode_of(gi, mode_q) == DUTCL_MODE_GMEM;
            assign gmem_pend[gi] = gmem[gi] && load_q[gi];
            assign fire[gi] = load_q[gi] && dac_data_ready[gi] &&
                ((mode_of(gi, mode_q) == DUTCL_MODE_MEM) ||
                 (gmem[gi] && gmem_all_ready));
        end
    endgenerate

    // Every global member must be pending and have its data in place
    assign gmem_all_ready = (gmem_pend != '0) &&
        ((gmem & ~(load_q & dac_data_ready)) == '0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_q <= `DUTCL_BITS_RST;
        end else begin
            for (int i = 0; i < NDAC; i++) begin
                if (fire[i]) begin
                    load_q[i] <= 1'b0;
                end else if (wr_go && waddr_q == `DUTCL_OFS_LOAD &&
                    wstrb_q[0] && wdata_q[i] &&
                    (mode_of(i, mode_q) == DUTCL_MODE_MEM ||
                     mode_of(i, mode_q) == DUTCL_MODE_GMEM)) begin
                    load_q[i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dac_update <= '0;
            dac_force_clear <= '0;
            seq_update <= '0;
        end else begin
            dac_update <= fire | upd_strobe;
            dac_force_clear <= clear_q;
            seq_update <= upd_strobe;
        end
    end

    // ****************************************
    // Ten microsecond tick and sequencer timers
    // ****************************************
    logic [TW-1:0] tick_q;
    logic tick;
    assign tick = (tick_q == TW'(TICK_CYC - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn || tick) begin
            tick_q <= '0;
        end else begin
            tick_q <= tick_q + 1'b1;
        end
    end

    generate
        for (gi = 0; gi < NDAC; gi++) begin : g_tmr
            logic timed;
            assign timed = run_q[gi] &&
                (mode_of(gi, mode_q) == DUTCL_MODE_FIFO ||
                 mode_of(gi, mode_q) == DUTCL_MODE_TIMER);
            dutcl_seq_timer #(.CW(PW)) u_tmr (
                .aclk(aclk),
                .aresetn(aresetn),
                .tick(tick),
                .run(timed),
                .preload(preload_q[gi]),
                .strobe(upd_strobe[gi])
            );
        end
    endgenerate

    // ****************************************
    // Read channel
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0000_0000;
            if (s_axi_araddr[11:5] == `DUTCL_OFS_PRELOAD0 >> 5) begin
                s_axi_rdata <= preload_q[s_axi_araddr[4:2]];
            end else if (s_axi_araddr == `DUTCL_OFS_CLEAR) begin
                s_axi_rdata[NDAC-1:0] <= clear_q;
            end else if (s_axi_araddr == `DUTCL_OFS_LOAD) begin
                s_axi_rdata[NDAC-1:0] <= load_q;
            end else if (s_axi_araddr == `DUTCL_OFS_MODE) begin
                s_axi_rdata[23:0] <= mode_q;
            end else if (s_axi_araddr == `DUTCL_OFS_RUN) begin
                s_axi_rdata[NDAC-1:0] <= run_q;
            end else if (s_axi_araddr == `DUTCL_OFS_READY) begin
                s_axi_rdata[NDAC-1:0] <= dac_data_ready;
            end else begin
                s_axi_rresp <= 2'h2;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_clear_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        1 |=> dac_force_clear == $past(clear_q))
        else $error("clear output does not follow clear bits");
    a_load_self_clr: assert property (@(posedge aclk) disable iff (!aresetn)
        fire[0] |=> !load_q[0] ##0 dac_update[0])
        else $error("load bit not cleared on update");
    a_load_mem_only: assert property (@(posedge aclk) disable iff (!aresetn)
        (!load_q[0] && mode_of(0, mode_q) inside {DUTCL_MODE_FIFO,
         DUTCL_MODE_TIMER, DUTCL_MODE_IMM}) |=> !load_q[0])
        else $error("load bit set outside memory mode");
    a_pend_wait: assert property (@(posedge aclk) disable iff (!aresetn)
        (load_q[1] && !dac_data_ready[1]) |=> load_q[1])
        else $error("load request dropped before data ready");
    a_gmem_together: assert property (@(posedge aclk) disable iff (!aresetn)
        (fire[1] && gmem[1] && gmem[2]) |-> fire[2])
        else $error("global members not updated together");
    a_tick_period: assert property (@(posedge aclk) disable iff (!aresetn)
        tick |=> !tick [*8] ##0 (tick_q == TW'(7)))
        else $error("tick period wrong");
    a_timer_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        !(run_q[3] && mode_of(3, mode_q) inside {DUTCL_MODE_FIFO,
         DUTCL_MODE_TIMER}) |=> !upd_strobe[3])
        else $error("timer strobe outside timed mode");
    a_strobe_tick: assert property (@(posedge aclk) disable iff (!aresetn)
        upd_strobe[3] |-> $past(tick))
        else $error("timer strobe not on tick");
endmodule // dutcl_top

//--- hw/dutcl_cfg.svh
/*
 * Constants for the DAC update timer, clear and load control block.
 * Assumes inclusion by the block's design files and its test bench.
 */
`ifndef DUTCL_CFG_SVH
`define DUTCL_CFG_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define DUTCL_OFS_PRELOAD0 12'h060
`define DUTCL_OFS_CLEAR 12'h080
`define DUTCL_OFS_LOAD 12'h084
`define DUTCL_OFS_MODE 12'h0a0
`define DUTCL_OFS_RUN 12'h0a4
`define DUTCL_OFS_READY 12'h0a8

// ****************************************
// Reset values and field layout
// ****************************************
`define DUTCL_PRELOAD_RST 32'h0000_0000
`define DUTCL_BITS_RST 8'h00
`define DUTCL_MODE_RST 24'h00_0000
`define DUTCL_MODE_W 3

// ****************************************
// Timing
// ****************************************
`define DUTCL_CLK_HZ 125000000
`define DUTCL_TICK_NS 10000
`define DUTCL_OSC_HZ 40000000

`endif

//--- hw/dutcl_pkg.sv
/*
 * Types for the DAC update timer, clear and load control block.
 * Assumes the constants header is on the include path.
 */
package dutcl_pkg;
    // Per-DAC operating mode, three-bit field in the mode register
    typedef enum logic [2:0] {
        DUTCL_MODE_IMM = 3'h0,
        DUTCL_MODE_MEM = 3'h1,
        DUTCL_MODE_GMEM = 3'h2,
        DUTCL_MODE_FIFO = 3'h3,
        DUTCL_MODE_TIMER = 3'h4
    } dutcl_mode_t;

    typedef enum logic [2:0] {
        DUTCL_ST_IDLE = 3'b001,
        DUTCL_ST_WDATA = 3'b010,
        DUTCL_ST_RESP = 3'b100
    } dutcl_wst_t;
endpackage

//--- hw/dutcl_seq_timer.sv
/*
 * One sequencer interval timer for a single quad DAC.
 * Assumes a tick pulse of one cycle every ten microseconds.
 */
`timescale 1ns/10ps
`include "dutcl_cfg.svh"

module dutcl_seq_timer import dutcl_pkg::*; #(
    parameter int CW = 32
) (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Sync reset, active low
    input wire logic tick, // Ten microsecond tick
    input wire logic run, // Sequencer running in timed mode
    input wire logic [CW-1:0] preload, // Interval preload value
    output logic strobe // One pulse per expiry
);
    logic [CW-1:0] cnt_q;
    logic run_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            strobe <= 1'b0;
        end else begin
            run_q <= run;
            strobe <= 1'b0;
            if (!run) begin
                cnt_q <= preload;
            end else if (!run_q) begin
                cnt_q <= preload;
            end else if (tick) begin
                if (cnt_q == '0) begin
                    cnt_q <= preload;
                    strobe <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end
endmodule // dutcl_seq_timer

//--- tb/dutcl_dac_model.sv
/*
 * Behavioural model of the eight quad DACs behind the control block.
 * Assumes clear and update levels come from the control block.
 */
`timescale 1ns/10ps

module dutcl_dac_model (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Sync reset, active low
    input wire logic [7:0] stall, // Channel data still moving
    input wire logic [7:0] dac_force_clear, // Clear level per DAC
    input wire logic [7:0] dac_update, // Output update pulse
    output logic [7:0] dac_data_ready, // All channel data moved
    output logic [7:0] at_clear // Outputs held at clear value
);
    logic [7:0] busy_q;

    // Outputs stay at clear value until an update after clear is released
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_q <= 8'h00;
            dac_data_ready <= 8'h00;
            at_clear <= 8'h00;
        end else begin
            busy_q <= dac_update;
            dac_data_ready <= ~stall & ~dac_update & ~busy_q;
            at_clear <= dac_force_clear | (at_clear & ~dac_update);
        end
    end
endmodule // dutcl_dac_model

//--- tb/dac_update_timer_clear_load_test.sv
/*
 * Self-checking bench for the DAC update control block.
 * Assumes the block's header and package are compiled first.
 */
`timescale 1ns/10ps
`include "dutcl_cfg.svh"

module dac_update_timer_clear_load_test import dutcl_pkg::*;;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d, v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [7:0] ready, fclr, upd, sequ, stall, at_clr;
    logic [23:0] modes;
    int err_total, comparisons, n0, p;
    int n_upd[8];
    int n_seq[8];
    localparam int TICK_CYC =
        (`DUTCL_CLK_HZ / 1000) * `DUTCL_TICK_NS / 1000000;

    dutcl_top dutcl_top_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .dac_data_ready(ready),
        .dac_force_clear(fclr), .dac_update(upd), .seq_update(sequ)
    );

    dutcl_dac_model dutcl_dac_model_inst (
        .aclk(aclk), .aresetn(aresetn), .stall(stall),
        .dac_force_clear(fclr), .dac_update(upd),
        .dac_data_ready(ready), .at_clear(at_clr)
    );

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        for (int i = 0; i < 8; i++) begin
            n_upd[i] <= n_upd[i] + int'(upd[i]);
            n_seq[i] <= n_seq[i] + int'(sequ[i]);
        end
    end

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    function automatic logic [1:0] resp_of(input logic [11:0] a);
        if (a >= `DUTCL_OFS_PRELOAD0 && a <= `DUTCL_OFS_LOAD)
            return 2'h0;
        if (a >= `DUTCL_OFS_MODE && a <= `DUTCL_OFS_READY)
            return 2'h0;
        return 2'h2;
    endfunction

    task automatic wr(input logic [11:0] a, input logic [31:0] dat);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= dat;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        check(bresp, resp_of(a));
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] dat);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        dat = rdata;
        check(rresp, resp_of(a));
    endtask

    task automatic set_mode(input int k, input dutcl_mode_t m);
        modes[3*k +: 3] = m;
        wr(`DUTCL_OFS_MODE, {8'h00, modes});
    endtask

    task automatic wait_upd(input logic [7:0] m);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while ((upd & m) == 8'h00 && n < 200);
        check(upd & m, m);
    endtask

    task automatic interval(input int k, input int pv);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!sequ[k] && n < 5000);
        check(upd[k], 1'b1);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!sequ[k] && n < 5000);
        check(n, (pv + 1) * TICK_CYC);
    endtask

    task automatic stop_test;
        $display("counts: %0d compared, %0d wrong", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge aclk);
        err_total++;
        $display("wrong value at %0t: watchdog expired", $time);
        stop_test;
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        void'($urandom(32'ha679));
        // Response readies held high for the whole run
        {awvalid, wvalid, bready, arvalid, rready} <= 5'b00101;
        {awaddr, araddr, wdata} <= 56'h0;
        wstrb <= 4'hf;
        stall <= 8'h00;
        aresetn <= 1'b0;
        modes = 24'h00_0000;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`DUTCL_OFS_PRELOAD0, d);
        check(d, `DUTCL_PRELOAD_RST);
        rd(`DUTCL_OFS_CLEAR, d);
        check(d[7:0], `DUTCL_BITS_RST);
        rd(`DUTCL_OFS_LOAD, d);
        check(d[7:0], `DUTCL_BITS_RST);
        v = $urandom;
        wr(`DUTCL_OFS_PRELOAD0 + 12'h01c, v);
        rd(`DUTCL_OFS_PRELOAD0 + 12'h01c, d);
        check(d, v);
        wr(12'h0f0, $urandom);
        rd(12'h0f0, d);
        check(d, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 32'hff : (i == 1) ? 32'h0 : $urandom & 32'hff;
            wr(`DUTCL_OFS_CLEAR, v);
            repeat (3) @(posedge aclk);
            check(fclr, v[7:0]);
            check(at_clr & v[7:0], v[7:0]);
            rd(`DUTCL_OFS_CLEAR, d);
            check(d[7:0], v[7:0]);
        end
        wr(`DUTCL_OFS_CLEAR, 32'h0);
        $display("test clear done");
        n0 = n_upd[0];
        wr(`DUTCL_OFS_LOAD, 32'h1);
        repeat (20) @(posedge aclk);
        rd(`DUTCL_OFS_LOAD, d);
        check(d[0], 1'b0);
        check(n_upd[0] - n0, 0);
        set_mode(0, DUTCL_MODE_MEM);
        stall <= 8'h01;
        wr(`DUTCL_OFS_LOAD, 32'h1);
        n0 = n_upd[0];
        repeat ($urandom_range(30, 5)) @(posedge aclk);
        rd(`DUTCL_OFS_LOAD, d);
        check(d[0], 1'b1);
        check(n_upd[0] - n0, 0);
        stall <= 8'h00;
        wait_upd(8'h01);
        repeat (2) @(posedge aclk);
        // New data only once the bit reads clear
        rd(`DUTCL_OFS_LOAD, d);
        check(d[0], 1'b0);
        set_mode(1, DUTCL_MODE_GMEM);
        set_mode(2, DUTCL_MODE_GMEM);
        stall <= 8'h06;
        wr(`DUTCL_OFS_LOAD, 32'h6);
        stall <= 8'h04;
        n0 = n_upd[1];
        repeat ($urandom_range(30, 10)) @(posedge aclk);
        check(n_upd[1] - n0, 0);
        stall <= 8'h00;
        wait_upd(8'h06);
        repeat (2) @(posedge aclk);
        rd(`DUTCL_OFS_LOAD, d);
        check(d[2:1], 2'b00);
        $display("test load done");
        set_mode(3, DUTCL_MODE_TIMER);
        set_mode(5, DUTCL_MODE_FIFO);
        rd(`DUTCL_OFS_MODE, d);
        check(d[23:0], modes);
        for (int k = 3; k < 6; k += 2) begin
            p = (k == 3) ? 0 : $urandom_range(2, 0);
            wr(`DUTCL_OFS_PRELOAD0 + 12'(4 * k), p);
            n0 = n_seq[4];
            wr(`DUTCL_OFS_RUN, 32'h18 | (32'h1 << k));
            interval(k, p);
            check(n_seq[4] - n0, 0);
            wr(`DUTCL_OFS_RUN, 32'h0);
        end
        $display("test timer done");
        stop_test;
    end
endmodule // dac_update_timer_clear_load_test
